// >>> rtl/dtu_cfg.svh
// Constants of the dual timer and up/down timer block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef DTU_CFG_SVH
`define DTU_CFG_SVH
// Register indices; byte address is four times the index
`define DTU_IDX_U01_CTRL 8'h88
`define DTU_IDX_U01_MODE 8'h89
`define DTU_IDX_U0_LO    8'h8a
`define DTU_IDX_U1_LO    8'h8b
`define DTU_IDX_U0_HI    8'h8c
`define DTU_IDX_U1_HI    8'h8d
`define DTU_IDX_U2_CTRL  8'hc8
`define DTU_IDX_U2_MODE  8'hc9
`define DTU_IDX_RLD_LO   8'hca
`define DTU_IDX_RLD_HI   8'hcb
`define DTU_IDX_U2_LO    8'hcc
`define DTU_IDX_U2_HI    8'hcd
`define DTU_IDX_IRQ_STAT 8'he8
`define DTU_IDX_IRQ_MASK 8'he9
`define DTU_RST_BYTE     8'h00
// Control bits of units 0 and 1
`define DTU_B_OVF1 7
`define DTU_B_RUN1 6
`define DTU_B_OVF0 5
`define DTU_B_RUN0 4
// Mode nibble: gate, source, two mode bits; unit 1 sits in the upper nibble
`define DTU_B_GATE 3
`define DTU_B_SRC  2
`define DTU_NIB1   4
`define DTU_PRE_W  5
// Control bits of unit 2
`define DTU_B_OVF2   7
`define DTU_B_EXTF   6
`define DTU_B_RXBAUD 5
`define DTU_B_TXBAUD 4
`define DTU_B_EXTEN  3
`define DTU_B_RUN2   2
`define DTU_B_SRC2   1
`define DTU_B_CAPSEL 0
`define DTU_B_DIR    0
// Pin vector positions
`define DTU_P_GATE0 0
`define DTU_P_GATE1 1
`define DTU_P_EV0   2
`define DTU_P_EV1   3
`define DTU_P_EV2   4
`define DTU_P_TRIG  5
`define DTU_NPIN    6
// Interrupt status bits
`define DTU_I_OVF0 0
`define DTU_I_OVF1 1
`define DTU_I_OVF2 2
`define DTU_I_EXTF 3
`define DTU_NIRQ   4
// Oscillator clocks per machine cycle
`define DTU_MC_DIV 12
`endif

// >>> rtl/dtu_pkg.sv
// Types of the dual timer and up/down timer block.
// Assumes dtu_cfg.svh is on the include path.
`default_nettype none
`include "dtu_cfg.svh"
package dtu_pkg;
	// Operating modes of units 0 and 1
	typedef enum logic [1:0] {
		DTU_MODE_PRESC  = 2'b00,
		DTU_MODE_16     = 2'b01,
		DTU_MODE_RELOAD = 2'b10,
		DTU_MODE_SPLIT  = 2'b11
	} dtu_mode_type;

	// Whole state of the block
	typedef struct packed {
		logic [3:0]           mc_cnt;
		logic                 half;
		logic [`DTU_NPIN-1:0] sync1;
		logic [`DTU_NPIN-1:0] sync2;
		logic [`DTU_NPIN-1:0] samp;
		logic [`DTU_NPIN-1:0] prev;
		logic [7:0]           u01_ctrl;
		logic [7:0]           u01_mode;
		logic [7:0]           u0_lo;
		logic [7:0]           u0_hi;
		logic [7:0]           u1_lo;
		logic [7:0]           u1_hi;
		logic [7:0]           u2_ctrl;
		logic                 count_direction_enable;
		logic [7:0]           rld_lo;
		logic [7:0]           rld_hi;
		logic [7:0]           u2_lo;
		logic [7:0]           u2_hi;
		logic [`DTU_NIRQ-1:0] irq_stat;
		logic [`DTU_NIRQ-1:0] irq_mask;
		logic                 ack;
		logic [7:0]           rdata;
	} dtu_state_type;
endpackage
`default_nettype wire

// >>> rtl/dtu_timer.sv
// Two mode-selectable timer/counters and a 16-bit up/down timer,
// reached as byte registers over a classic Wishbone slave.
// Assumes clk_i is the oscillator and the pins are asynchronous.
//
// What this block does
// (R1) Mode 00 makes a unit an 8-bit counter behind a divide-by-32 prescaler.
// (R2) Mode 10 counts the low byte and reloads it from the high byte on overflow.
// (R3) Mode 11 splits unit 0 into two 8-bit counters and stops unit 1.
// (R4) With the source bit clear a unit counts once per machine cycle, fosc/12.
// (R5) In counter operation a unit counts each falling edge of its event pin.
// (R6) Edge detection takes two machine cycles, so pin rates stay below fosc/24.
// (R7) A gate pin enables its unit when the gate setting is on.
// (R8) The control register holds overflow and run of unit 1 at bits 7:6, unit 0 at 5:4.
// (R9) Unit 2 is 16 bits and bit 1 of its control selects timer or counter.
// (R10) In reload mode unit 2 loads the reload register on every up-count overflow.
// (R11) With external enable a trigger pin falling edge also reloads unit 2.
// (R12) With direction enable unit 2 counts down while the trigger pin is low.
// (R13) In capture mode unit 2 counts up and a trigger edge captures the count.
// (R14) A baud select with the source bit clear makes unit 2 count at fosc/2 without raising its overflow flag.
// (R15) Unit 2 mode register holds direction enable at bit 0, reset 0, rest reserved.
// (R16) A unit counts while run is set and its gate allows; overflow sets its flag.
// (R17) Mode register: upper nibble unit 1, lower unit 0, each gate, source, mode.
//
// Chosen here: the Wishbone register port.
`default_nettype none
`include "dtu_cfg.svh"
module dtu_timer import dtu_pkg::*; #(
	parameter int MC_DIV = `DTU_MC_DIV
) (
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [9:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        first_gate_pin_i,
	input  wire logic        second_gate_pin_i,
	input  wire logic        first_event_pin_i,
	input  wire logic        second_event_pin_i,
	input  wire logic        updown_event_pin_i,
	input  wire logic        updown_trigger_pin_i,
	output logic             irq_o
);

	dtu_state_type st;
	dtu_state_type next_st;

	// One step of unit 0 or 1; result is {overflow, high, low}
	function automatic logic [16:0] dtu_step(input dtu_mode_type m, input logic inc,
		input logic [7:0] lo, input logic [7:0] hi);
		logic [16:0] r;
		logic [13:0] c13;
		logic [8:0]  c8;
		r = {1'b0, hi, lo};
		c13 = {1'b0, hi, lo[`DTU_PRE_W-1:0]} + 14'h1;
		c8 = {1'b0, lo} + 9'h1;
		if (inc) begin
			case (m)
				// (R1) prescaled 8-bit
				DTU_MODE_PRESC: r = {c13[13], c13[12:`DTU_PRE_W], lo[7:`DTU_PRE_W],
					c13[`DTU_PRE_W-1:0]};
				DTU_MODE_16: r = {1'b0, hi, lo} + 17'h1;
				// (R2) low byte reload
				DTU_MODE_RELOAD: r = c8[8] ? {1'b1, hi, hi} : {1'b0, hi, c8[7:0]};
				default: r = {c8[8], hi, c8[7:0]};
			endcase
		end
		return r;
	endfunction

	logic [`DTU_NPIN-1:0] pins;
	logic [`DTU_NPIN-1:0] fall;
	logic                 mc_tick;
	dtu_mode_type         mode0;
	dtu_mode_type         mode1;
	logic                 first_unit_run;
	logic                 second_unit_run;
	logic                 inc0;
	logic                 inc1;
	logic                 split_inc;
	logic                 split_ovf;
	logic [16:0]          r0;
	logic [16:0]          r1;
	logic                 ovf0;
	logic                 ovf1;
	logic [15:0]          u2_cnt;
	logic [15:0]          rld;
	logic                 baud;
	logic                 capture_or_reload_select;
	logic                 u2_inc;
	logic                 u2_down;
	logic                 u2_ovf;
	logic                 ext_ev;
	logic                 ovf2_set;
	logic                 wr;
	logic [7:0]           idx;
	logic [7:0]           wdat;

	assign pins = {updown_trigger_pin_i, updown_event_pin_i, second_event_pin_i,
		first_event_pin_i, second_gate_pin_i, first_gate_pin_i};

	// Machine cycle tick and edges sampled once per machine cycle
	assign mc_tick = st.mc_cnt == 4'(MC_DIV - 1);
	// (R6) falling edge seen over two machine cycles
	assign fall = {`DTU_NPIN{mc_tick}} & st.prev & ~st.samp;

	// (R17) mode nibbles
	assign mode0 = dtu_mode_type'(st.u01_mode[1:0]);
	assign mode1 = dtu_mode_type'(st.u01_mode[`DTU_NIB1 +: 2]);
	assign first_unit_run = st.u01_ctrl[`DTU_B_RUN0];
	assign second_unit_run = st.u01_ctrl[`DTU_B_RUN1];

	// (R16) run and gate; (R7) gate pins; (R4) machine cycle; (R5) event edges
	assign inc0 = first_unit_run
		& (~st.u01_mode[`DTU_B_GATE] | st.sync2[`DTU_P_GATE0])
		& (st.u01_mode[`DTU_B_SRC] ? fall[`DTU_P_EV0] : mc_tick);
	// (R3) unit 1 held in split mode
	assign inc1 = second_unit_run & (mode1 != DTU_MODE_SPLIT)
		& (~st.u01_mode[`DTU_NIB1 + `DTU_B_GATE] | st.sync2[`DTU_P_GATE1])
		& (st.u01_mode[`DTU_NIB1 + `DTU_B_SRC] ? fall[`DTU_P_EV1] : mc_tick);
	// (R3) upper byte of unit 0 is a plain timer run by unit 1's run bit
	assign split_inc = (mode0 == DTU_MODE_SPLIT) & second_unit_run & mc_tick;
	assign split_ovf = split_inc & (st.u0_hi == 8'hff);
	assign r0 = dtu_step(mode0, inc0, st.u0_lo, st.u0_hi);
	assign r1 = dtu_step(mode1, inc1, st.u1_lo, st.u1_hi);
	assign ovf0 = r0[16];
	assign ovf1 = r1[16] | split_ovf;

	// Unit 2 count sources and direction
	assign u2_cnt = {st.u2_hi, st.u2_lo};
	assign rld = {st.rld_hi, st.rld_lo};
	assign baud = st.u2_ctrl[`DTU_B_RXBAUD] | st.u2_ctrl[`DTU_B_TXBAUD];
	assign capture_or_reload_select = st.u2_ctrl[`DTU_B_CAPSEL];
	// (R9) timer or counter; (R14) half oscillator rate for baud use
	assign u2_inc = st.u2_ctrl[`DTU_B_RUN2] & (st.u2_ctrl[`DTU_B_SRC2] ? fall[`DTU_P_EV2]
		: (baud ? st.half : mc_tick));
	// (R12) down count while trigger pin low; (R13) capture counts up only
	assign u2_down = st.count_direction_enable & ~capture_or_reload_select & ~baud
		& ~st.sync2[`DTU_P_TRIG];
	assign u2_ovf = u2_inc & (u2_down ? (u2_cnt == rld) : (u2_cnt == 16'hffff));
	assign ext_ev = fall[`DTU_P_TRIG] & st.u2_ctrl[`DTU_B_EXTEN];
	// (R14) no overflow flag in baud use
	assign ovf2_set = u2_ovf & ~baud;

	// Bus decode; writes land on the edge where the master sees ack
	assign idx = wb_adr_i[9:2];
	assign wdat = wb_dat_i[7:0];
	assign wr = wb_cyc_i & wb_stb_i & wb_we_i & st.ack & wb_sel_i[0];

	// Next state
	always_comb begin
		next_st = st;
		next_st.mc_cnt = mc_tick ? 4'h0 : st.mc_cnt + 4'h1;
		next_st.half = ~st.half;
		next_st.sync1 = pins;
		next_st.sync2 = st.sync1;
		if (mc_tick) begin
			next_st.samp = st.sync2;
			next_st.prev = st.samp;
		end
		{next_st.u0_hi, next_st.u0_lo} = r0[15:0];
		{next_st.u1_hi, next_st.u1_lo} = r1[15:0];
		if (split_inc) begin
			next_st.u0_hi = st.u0_hi + 8'h1;
		end
		// Unit 2 counting, wrap and reload
		if (u2_inc) begin
			if (u2_down) begin
				// (R12) underflow at reload value wraps to all ones
				{next_st.u2_hi, next_st.u2_lo} = u2_ovf ? 16'hffff : u2_cnt - 16'h1;
			end else if (u2_ovf && !capture_or_reload_select) begin
				// (R10) reload on overflow
				{next_st.u2_hi, next_st.u2_lo} = rld;
			end else if (u2_ovf && baud) begin
				{next_st.u2_hi, next_st.u2_lo} = rld;
			end else begin
				{next_st.u2_hi, next_st.u2_lo} = u2_cnt + 16'h1;
			end
		end
		if (ext_ev && !baud) begin
			if (capture_or_reload_select) begin
				// (R13) capture the count
				{next_st.rld_hi, next_st.rld_lo} = u2_cnt;
			end else if (!st.count_direction_enable) begin
				// (R11) trigger reload
				{next_st.u2_hi, next_st.u2_lo} = rld;
			end
		end
		// Software writes; count data from software wins
		if (wr) begin
			case (idx)
				`DTU_IDX_U01_CTRL: next_st.u01_ctrl = wdat;
				`DTU_IDX_U01_MODE: next_st.u01_mode = wdat;
				`DTU_IDX_U0_LO: next_st.u0_lo = wdat;
				`DTU_IDX_U1_LO: next_st.u1_lo = wdat;
				`DTU_IDX_U0_HI: next_st.u0_hi = wdat;
				`DTU_IDX_U1_HI: next_st.u1_hi = wdat;
				`DTU_IDX_U2_CTRL: next_st.u2_ctrl = wdat;
				// (R15) only bit 0 is stored
				`DTU_IDX_U2_MODE: next_st.count_direction_enable = wdat[`DTU_B_DIR];
				`DTU_IDX_RLD_LO: next_st.rld_lo = wdat;
				`DTU_IDX_RLD_HI: next_st.rld_hi = wdat;
				`DTU_IDX_U2_LO: next_st.u2_lo = wdat;
				`DTU_IDX_U2_HI: next_st.u2_hi = wdat;
				`DTU_IDX_IRQ_STAT: next_st.irq_stat = st.irq_stat & ~wdat[`DTU_NIRQ-1:0];
				`DTU_IDX_IRQ_MASK: next_st.irq_mask = wdat[`DTU_NIRQ-1:0];
				default: next_st.irq_mask = st.irq_mask;
			endcase
		end
		// (R8) (R16) hardware flag set wins over a software clear
		if (ovf0) begin
			next_st.u01_ctrl[`DTU_B_OVF0] = 1'b1;
		end
		if (ovf1) begin
			next_st.u01_ctrl[`DTU_B_OVF1] = 1'b1;
		end
		if (ovf2_set) begin
			next_st.u2_ctrl[`DTU_B_OVF2] = 1'b1;
		end
		if (ext_ev) begin
			next_st.u2_ctrl[`DTU_B_EXTF] = 1'b1;
		end
		// Sticky interrupt status, set wins over write-one-to-clear
		next_st.irq_stat[`DTU_I_OVF0] = next_st.irq_stat[`DTU_I_OVF0] | ovf0;
		next_st.irq_stat[`DTU_I_OVF1] = next_st.irq_stat[`DTU_I_OVF1] | ovf1;
		next_st.irq_stat[`DTU_I_OVF2] = next_st.irq_stat[`DTU_I_OVF2] | ovf2_set;
		next_st.irq_stat[`DTU_I_EXTF] = next_st.irq_stat[`DTU_I_EXTF] | ext_ev;
		// Bus answer one cycle after the request, dropped the cycle after
		next_st.ack = wb_cyc_i & wb_stb_i & ~st.ack;
		next_st.rdata = `DTU_RST_BYTE;
		if (wb_cyc_i && wb_stb_i && !st.ack) begin
			case (idx)
				`DTU_IDX_U01_CTRL: next_st.rdata = st.u01_ctrl;
				`DTU_IDX_U01_MODE: next_st.rdata = st.u01_mode;
				`DTU_IDX_U0_LO: next_st.rdata = st.u0_lo;
				`DTU_IDX_U1_LO: next_st.rdata = st.u1_lo;
				`DTU_IDX_U0_HI: next_st.rdata = st.u0_hi;
				`DTU_IDX_U1_HI: next_st.rdata = st.u1_hi;
				`DTU_IDX_U2_CTRL: next_st.rdata = st.u2_ctrl;
				`DTU_IDX_U2_MODE: next_st.rdata = {7'h00, st.count_direction_enable};
				`DTU_IDX_RLD_LO: next_st.rdata = st.rld_lo;
				`DTU_IDX_RLD_HI: next_st.rdata = st.rld_hi;
				`DTU_IDX_U2_LO: next_st.rdata = st.u2_lo;
				`DTU_IDX_U2_HI: next_st.rdata = st.u2_hi;
				`DTU_IDX_IRQ_STAT: next_st.rdata = {4'h0, st.irq_stat};
				`DTU_IDX_IRQ_MASK: next_st.rdata = {4'h0, st.irq_mask};
				default: next_st.rdata = `DTU_RST_BYTE;
			endcase
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Outputs
	assign wb_ack_o = st.ack;
	assign wb_dat_o = {24'h000000, st.rdata};
	assign irq_o = |(st.irq_stat & st.irq_mask);

	default clocking dtu_cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);

	// Overflow of unit 0 reaches its flag and its status bit
	a_first_ovf_flag: assert property ( // (R16)
		ovf0 |=> st.u01_ctrl[`DTU_B_OVF0] && st.irq_stat[`DTU_I_OVF0])
		else $error("unit 0 overflow did not set its flags");

	// Stopped unit 0 holds its low byte
	a_first_stopped: assert property ( // (R16)
		!first_unit_run && !wr |=> $stable(st.u0_lo))
		else $error("unit 0 counted while stopped");

	// Timer use counts only on machine cycle ticks, by one
	a_first_rate: assert property ( // (R4)
		inc0 && mode0 == DTU_MODE_16 && !st.u01_mode[`DTU_B_SRC] && !wr
		|-> mc_tick ##1 {st.u0_hi, st.u0_lo} == $past({st.u0_hi, st.u0_lo}) + 16'h1)
		else $error("unit 0 timer step wrong");

	// Low byte reloads from high byte
	a_reload_byte: assert property ( // (R2)
		inc0 && mode0 == DTU_MODE_RELOAD && st.u0_lo == 8'hff && !wr
		|=> st.u0_lo == $past(st.u0_hi) && st.u01_ctrl[`DTU_B_OVF0])
		else $error("unit 0 low byte did not reload");

	// Unit 1 frozen in split mode
	a_split_stop: assert property ( // (R3)
		mode1 == DTU_MODE_SPLIT && !wr |=> $stable({st.u1_hi, st.u1_lo}))
		else $error("unit 1 counted in split mode");

	// Edges come no closer than nine clocks apart
	a_edge_spacing: assert property ( // (R6)
		fall[`DTU_P_EV0] |=> !fall[`DTU_P_EV0] [*8])
		else $error("event edges too close");

	// Up overflow in reload mode loads the reload value
	sequence s_u2_wrap;
		u2_ovf && !u2_down && !capture_or_reload_select && !wr;
	endsequence
	sequence s_u2_loaded;
		{st.u2_hi, st.u2_lo} == $past(rld);
	endsequence
	a_u2_reload: assert property ( // (R10)
		s_u2_wrap ##0 !ext_ev |=> s_u2_loaded)
		else $error("unit 2 did not reload on overflow");

	// Trigger edge captures the count
	a_u2_capture: assert property ( // (R13)
		ext_ev && capture_or_reload_select && !baud && !wr
		|=> rld == $past(u2_cnt) && st.u2_ctrl[`DTU_B_EXTF])
		else $error("unit 2 capture missed");

	// Baud use never raises the overflow flag
	a_u2_baud_flag: assert property ( // (R14)
		baud && !wr && !st.u2_ctrl[`DTU_B_OVF2] |=> !st.u2_ctrl[`DTU_B_OVF2])
		else $error("overflow flag raised in baud use");

	// (R8) Unit 1 overflow flags
	a_second_ovf_flag: assert property ( // (R8)
		ovf1 |=> st.u01_ctrl[`DTU_B_OVF1] && st.irq_stat[`DTU_I_OVF1])
		else $error("unit 1 overflow did not set its flags");

	// (R1) Prescaler not full holds the count byte
	a_presc_hold: assert property ( // (R1)
		inc0 && mode0 == DTU_MODE_PRESC && st.u0_lo[`DTU_PRE_W-1:0] != '1 && !wr
		|=> $stable(st.u0_hi))
		else $error("unit 0 count byte moved before prescaler carry");

	// (R1) Full prescaler steps the count byte
	a_presc_step: assert property ( // (R1)
		inc0 && mode0 == DTU_MODE_PRESC && st.u0_lo[`DTU_PRE_W-1:0] == '1 && !wr
		|=> st.u0_hi == $past(st.u0_hi) + 8'h1)
		else $error("unit 0 prescaler carry lost");

	// (R7) Closed gate holds unit 0 outside split mode
	a_gate_closed: assert property ( // (R7)
		st.u01_mode[`DTU_B_GATE] && !st.sync2[`DTU_P_GATE0] && mode0 != DTU_MODE_SPLIT
		&& !wr |=> $stable({st.u0_hi, st.u0_lo}))
		else $error("unit 0 counted with its gate closed");

	// (R5) Counter use steps only at a sampled edge
	a_event_only: assert property ( // (R5)
		st.u01_mode[`DTU_B_SRC] && !fall[`DTU_P_EV0] && mode0 == DTU_MODE_16 && !wr
		|=> $stable({st.u0_hi, st.u0_lo}))
		else $error("unit 0 counted without an event edge");

	// (R3) Split upper byte overflow sets the unit 1 flag
	a_split_ovf: assert property ( // (R3)
		split_inc && st.u0_hi == 8'hff && !wr
		|=> st.u01_ctrl[`DTU_B_OVF1] && st.u0_hi == 8'h00)
		else $error("split upper byte overflow lost");

	// (R9) Counter source steps unit 2 only at an event edge
	a_u2_source: assert property ( // (R9)
		st.u2_ctrl[`DTU_B_SRC2] && !fall[`DTU_P_EV2] && !ext_ev && !wr
		|=> $stable(u2_cnt))
		else $error("unit 2 counted without an event edge");

	// (R11) Trigger edge reloads unit 2
	a_u2_trigger: assert property ( // (R11)
		ext_ev && !capture_or_reload_select && !st.count_direction_enable && !baud && !wr
		|=> u2_cnt == $past(rld))
		else $error("unit 2 trigger reload missed");

	// (R12) Down count steps by one
	a_u2_down_step: assert property ( // (R12)
		u2_inc && u2_down && !u2_ovf && !wr |=> u2_cnt == $past(u2_cnt) - 16'h1)
		else $error("unit 2 down step wrong");

	// (R12) Down count at the reload value wraps and flags
	a_u2_down_wrap: assert property ( // (R12)
		u2_inc && u2_down && u2_ovf && !wr |=> u2_cnt == 16'hffff && st.u2_ctrl[`DTU_B_OVF2])
		else $error("unit 2 down wrap wrong");

	// (R14) Baud use steps only on alternate clocks
	a_u2_baud_rate: assert property ( // (R14)
		st.u2_ctrl[`DTU_B_RUN2] && baud && !st.u2_ctrl[`DTU_B_SRC2] && !st.half && !wr
		|=> $stable(u2_cnt))
		else $error("unit 2 baud count too fast");

endmodule // dtu_timer
`default_nettype wire

// >>> test/dtu_pins_model.sv
// Pin-side model: gate, event and trigger pins of the timer block.
// Assumes clk_i is the block's oscillator and MC matches its machine cycle.
`default_nettype none
module dtu_pins_model #(
	parameter int MC = 12
) (
	input  wire logic       clk_i,
	output logic      [5:0] pins_o
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle: all pins high, gates open
	initial pins_o = 6'h3f;

	// Moves one pin just after a clock edge
	task automatic set_pin(input int p, input logic v);
		@(posedge clk_i);
		pins_o[p] <= v;
	endtask

	// Slow falling edge
	// Each level held two machine cycles, so the rate stays at fosc/24 or below
	task automatic fall(input int p);
		set_pin(p, 1'b0);
		repeat (2 * MC) @(posedge clk_i);
		pins_o[p] <= 1'b1;
		repeat (2 * MC) @(posedge clk_i);
	endtask
endmodule // dtu_pins_model
`default_nettype wire

// >>> test/dual_timer_and_updown_timer_tb.sv
// Self-checking bench of the dual timer and up/down timer block.
// Assumes the design and the pin model are compiled before it.
`default_nettype none
module dual_timer_and_updown_timer_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk_i, sys_rst_i, cyc, stb, we, ack, irq;
	logic [9:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat;
	logic [5:0]  pins;
	logic [7:0]  q;
	int          failures = 0;
	int          total_checks = 0;
	int          cycles = 0;
	logic [7:0]  regs [14] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'hc8,
		8'hc9, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'he8, 8'he9};

	dtu_timer #(.MC_DIV(12)) dtu_timer_inst (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack),
		.first_gate_pin_i(pins[0]), .second_gate_pin_i(pins[1]),
		.first_event_pin_i(pins[2]), .second_event_pin_i(pins[3]),
		.updown_event_pin_i(pins[4]), .updown_trigger_pin_i(pins[5]), .irq_o(irq));
	dtu_pins_model #(.MC(12)) dtu_pins_model_inst (.clk_i(clk_i), .pins_o(pins));

	// Free-running oscillator
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	// Closing report
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Hang guard
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			summarize();
		end
	end

	// Compares one byte and counts it
	task automatic chk(input logic [7:0] i, input logic [7:0] s, input logic [7:0] e);
		total_checks++;
		if (s !== e) begin
			failures++;
			$display("MISMATCH reg %h expected %h seen %h", i, e, s);
		end
	endtask

	// One classic Wishbone cycle; ack and read data are taken at the same rising edge
	task automatic acc(input logic w, input logic [3:0] s, input logic [7:0] i,
		input logic [7:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= s;
		adr <= {i, 2'b00};
		wdat <= {24'h0, d};
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		acc(1'b1, 4'hf, i, d);
	endtask

	// Read and compare exactly
	task automatic rc(input logic [7:0] i, input logic [7:0] e);
		acc(1'b0, 4'hf, i, 8'h00);
		chk(i, q, e);
	endtask

	// Read and compare against a window of counts
	task automatic rng(input logic [7:0] i, input logic [7:0] lo, input logic [7:0] hi);
		acc(1'b0, 4'hf, i, 8'h00);
		chk(i, {7'h0, q >= lo && q <= hi}, 8'h01);
	endtask

	task automatic mc(input int n);
		repeat (n * 12) @(posedge clk_i);
	endtask

	// Main sequence
	initial begin
		sys_rst_i = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		sel = 4'h0;
		adr = 10'h0;
		wdat = 32'h0;
		repeat (3) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		foreach (regs[k]) rc(regs[k], 8'h00);
		wr(8'h80, 8'hff);
		rc(8'h80, 8'h00);
		// Lane 0 decides whether a write lands
		acc(1'b1, 4'h0, 8'h8a, 8'h5a);
		rc(8'h8a, 8'h00);
		acc(1'b1, 4'h1, 8'h8a, 8'h5a);
		rc(8'h8a, 8'h5a);
		wr(8'hc9, 8'hff);
		rc(8'hc9, 8'h01);
		wr(8'hc9, 8'h00);
		// Unit 0 16-bit timer overflows into flag and interrupt
		wr(8'h89, 8'h01);
		wr(8'he9, 8'h01);
		wr(8'h8a, 8'hfe);
		wr(8'h8c, 8'hff);
		wr(8'h88, 8'h10);
		for (int n = 0; n < 300 && irq !== 1'b1; n++) @(negedge clk_i);
		chk(8'hff, {7'h0, irq}, 8'h01);
		rc(8'he8, 8'h01);
		rc(8'h88, 8'h30);
		wr(8'he8, 8'h01);
		@(negedge clk_i);
		chk(8'hff, {7'h0, irq}, 8'h00);
		wr(8'h88, 8'h00);
		// Unit 1 behind the prescaler
		wr(8'h89, 8'h00);
		wr(8'h8b, 8'h00);
		wr(8'h8d, 8'h00);
		wr(8'h88, 8'h40);
		mc(40);
		wr(8'h88, 8'h00);
		rc(8'h8d, 8'h01);
		// Reload from high byte
		wr(8'h89, 8'h02);
		wr(8'h8a, 8'hfe);
		wr(8'h8c, 8'hf0);
		wr(8'h88, 8'h10);
		mc(6);
		wr(8'h88, 8'h00);
		rng(8'h8a, 8'hf2, 8'hf6);
		rc(8'h8c, 8'hf0);
		// Event counting on unit 0
		wr(8'h89, 8'h05);
		wr(8'h8a, 8'h00);
		wr(8'h8c, 8'h00);
		wr(8'h88, 8'h10);
		repeat (3) dtu_pins_model_inst.fall(2);
		wr(8'h88, 8'h00);
		rc(8'h8a, 8'h03);
		// Gate pin closes then opens unit 0
		wr(8'h89, 8'h09);
		wr(8'h8a, 8'h00);
		dtu_pins_model_inst.set_pin(0, 1'b0);
		wr(8'h88, 8'h10);
		mc(5);
		rc(8'h8a, 8'h00);
		dtu_pins_model_inst.set_pin(0, 1'b1);
		mc(5);
		wr(8'h88, 8'h00);
		rng(8'h8a, 8'h03, 8'h06);
		// Split mode stops unit 1
		wr(8'h89, 8'h33);
		wr(8'h8a, 8'h00);
		wr(8'h8c, 8'h00);
		wr(8'h8b, 8'h00);
		wr(8'h88, 8'h50);
		mc(5);
		wr(8'h88, 8'h00);
		rc(8'h8b, 8'h00);
		rng(8'h8c, 8'h03, 8'h06);
		// Unit 1 counts event edges only while its gate pin is high
		wr(8'h89, 8'hd0);
		wr(8'h8b, 8'h00);
		wr(8'h8d, 8'h00);
		dtu_pins_model_inst.set_pin(1, 1'b0);
		wr(8'h88, 8'h40);
		dtu_pins_model_inst.fall(3);
		rc(8'h8b, 8'h00);
		dtu_pins_model_inst.set_pin(1, 1'b1);
		repeat (2) dtu_pins_model_inst.fall(3);
		wr(8'h88, 8'h00);
		rc(8'h8b, 8'h02);
		// Unit 2 reload on overflow
		wr(8'hca, 8'h34);
		wr(8'hcb, 8'h12);
		wr(8'hcc, 8'hff);
		wr(8'hcd, 8'hff);
		wr(8'hc8, 8'h04);
		mc(3);
		rc(8'hc8, 8'h84);
		wr(8'hc8, 8'h00);
		rc(8'hcd, 8'h12);
		// Trigger edge reloads
		wr(8'hcc, 8'h00);
		wr(8'hcd, 8'h00);
		wr(8'hca, 8'h00);
		wr(8'hcb, 8'h55);
		wr(8'hc8, 8'h0c);
		dtu_pins_model_inst.fall(5);
		rc(8'hc8, 8'h4c);
		wr(8'hc8, 8'h00);
		rc(8'hcd, 8'h55);
		// Down counting while trigger is low
		wr(8'hc9, 8'h01);
		dtu_pins_model_inst.set_pin(5, 1'b0);
		wr(8'hcb, 8'h00);
		wr(8'hcc, 8'h10);
		wr(8'hcd, 8'h00);
		wr(8'hc8, 8'h04);
		mc(4);
		wr(8'hc8, 8'h00);
		rng(8'hcc, 8'h0b, 8'h0f);
		dtu_pins_model_inst.set_pin(5, 1'b1);
		wr(8'hc9, 8'h00);
		// Capture on trigger edge
		wr(8'hcc, 8'h00);
		wr(8'hcd, 8'h00);
		wr(8'hc8, 8'h0d);
		mc(4);
		dtu_pins_model_inst.fall(5);
		rc(8'hc8, 8'h4d);
		wr(8'hc8, 8'h00);
		rng(8'hca, 8'h03, 8'h0a);
		rc(8'hcb, 8'h00);
		// Baud generator overflows without the flag
		wr(8'he8, 8'hff);
		wr(8'hcc, 8'hf0);
		wr(8'hcd, 8'hff);
		wr(8'hc8, 8'h14);
		repeat (80) @(posedge clk_i);
		rc(8'hc8, 8'h14);
		wr(8'hc8, 8'h00);
		rc(8'hcd, 8'h00);
		rc(8'he8, 8'h00);
		// Unit 2 counts trigger-free event edges
		wr(8'hcc, 8'h00);
		wr(8'hcd, 8'h00);
		wr(8'hc8, 8'h06);
		repeat (2) dtu_pins_model_inst.fall(4);
		wr(8'hc8, 8'h00);
		rc(8'hcc, 8'h02);
		summarize();
	end
endmodule // dual_timer_and_updown_timer_tb
`default_nettype wire
